// File: hw/uart_core.sv
// Purpose: single-channel async serial port with Wishbone registers
// Assumes: 20 MHz clk_i, synchronous high reset, line pins synchronous
// Notes: 16x bit tick comes from the counter/timer reload
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic rxd_i,
   output logic txd_o,
   input wire logic multipurpose_input_i,
   output logic multipurpose_output_o,
   output logic irq_o
);
   import uart_pkg::*;
   state_s s_reg, s_next;
   logic req, wr, rd, tick, rx_act, push, cts_ok, tx_rdy, tx_emt;
   logic [7:0] wd, status, istat, rdat, rx_data, tx_mask;
   logic [3:0] cmd, nbits;
   logic [1:0] par_mode, ch_mode, wp;
   logic [5:0] stop_len;
   logic rx_line, rx_src, pe_now, fe_now;
   logic [2:0] head_flags;
   rx_entry_s head, entry;

   always_comb
   begin
      s_next = s_reg;
      req = cyc_i & stb_i & ~s_reg.ack;
      wr = req & we_i & sel_i[0];
      rd = req & ~we_i;
      wd = dat_i[7:0];
      cmd = wd[7:4];
      tick = 1'b0;
      push = 1'b0;
      entry = '0;
      pe_now = 1'b0;
      fe_now = 1'b0;
      rx_data = '0;
      rdat = '0;
      wp = '0;
      par_mode = s_reg.mode_one[4:3];
      ch_mode = s_reg.mode_two[7:6];
      nbits = 4'h5 + {2'h0, s_reg.mode_one[1:0]};
      tx_mask = 8'hFF >> (4'h8 - nbits);
      // Stop length in sixteenths of a bit
      if (s_reg.mode_two[3])
         stop_len = {2'h0, s_reg.mode_two[3:0]} + `STOP_LONG;
      else if (s_reg.mode_one[1:0] == 2'h0)
         stop_len = {2'h0, s_reg.mode_two[3:0]} + `STOP_SHORT
            + `STOP_FIVE;
      else
         stop_len = {2'h0, s_reg.mode_two[3:0]} + `STOP_SHORT;
      rx_line = (ch_mode == `CH_LOCAL) ? s_reg.tx_line : rxd_i;
      rx_act = s_reg.rx_en | (par_mode == `PAR_SPECIAL);
      cts_ok = ~s_reg.mode_two[`M2_CTSEN] | ~multipurpose_input_i;
      // Echo modes take the transmitter away from the host
      tx_rdy = s_reg.tx_en & ~s_reg.thr_full & (ch_mode[0] == 1'b0);
      tx_emt = tx_rdy & (s_reg.tx_st == TX_IDLE);
      head = s_reg.fifo[s_reg.rd_ptr];
      head_flags = (s_reg.cnt != 3'h0) ? {head.brk, head.fe, head.pe}
         : 3'h0;
      if (s_reg.mode_one[`M1_ERRMODE])
         head_flags = head_flags | s_reg.acc;
      rx_src = s_reg.mode_one[`M1_RXIRQ] ? (s_reg.cnt == `FIFO_DEPTH)
         : (s_reg.cnt != 3'h0);
      status = {head_flags, s_reg.ovr, tx_emt, tx_rdy,
         s_reg.cnt == `FIFO_DEPTH, s_reg.cnt != 3'h0};
      istat = {s_reg.mpi_chg, multipurpose_input_i, 1'b0, s_reg.ctr_rdy,
         s_reg.brk_chg, rx_src, tx_emt, tx_rdy};
      s_next.ack = req;
      // Register access
      if (adr_i == `OFS_MODE)
      begin
         rdat = s_reg.ptr ? s_reg.mode_two : s_reg.mode_one;
         if (wr & s_reg.ptr)
            s_next.mode_two = wd;
         else if (wr)
            s_next.mode_one = wd;
         if (req)
            s_next.ptr = 1'b1;
      end
      else if (adr_i == `OFS_CLKSEL)
      begin
         if (wr)
            s_next.clock_select = wd;
      end
      else if (adr_i == `OFS_COMMAND)
      begin
         if (wr)
         begin
            if (wd[3])
               s_next.tx_en = 1'b0;
            else if (wd[2])
               s_next.tx_en = 1'b1;
            if (wd[1])
            begin
               s_next.rx_en = 1'b0;
               s_next.rx_st = RX_IDLE;
            end
            else if (wd[0])
            begin
               s_next.rx_en = 1'b1;
               s_next.rx_st = RX_IDLE;
            end
            // Command field is decoded in one cycle; spacing is not needed
            case (cmd)
               `CMD_PTR_RST: s_next.ptr = 1'b0;
               `CMD_RX_RST:
               begin
                  s_next.rx_en = 1'b0;
                  s_next.cnt = 3'h0;
                  s_next.rd_ptr = 2'h0;
                  s_next.acc = 3'h0;
                  s_next.ovr = 1'b0;
                  s_next.rx_brk = 1'b0;
                  s_next.rx_st = RX_IDLE;
               end
               `CMD_TX_RST:
               begin
                  s_next.tx_en = 1'b0;
                  s_next.thr_full = 1'b0;
                  s_next.brk_tx = 1'b0;
                  s_next.tx_st = TX_IDLE;
                  s_next.tx_line = 1'b1;
               end
               `CMD_ERR_RST:
               begin
                  s_next.ovr = 1'b0;
                  s_next.acc = 3'h0;
                  s_next.fifo[s_reg.rd_ptr][10:8] = 3'h0;
               end
               `CMD_BRK_CLR: s_next.brk_chg = 1'b0;
               `CMD_BRK_START: s_next.brk_tx = s_next.tx_en;
               `CMD_BRK_STOP: s_next.brk_tx = 1'b0;
               `CMD_CT_START:
               begin
                  s_next.tmr = {s_reg.timer_preload_high,
                     s_reg.timer_preload_low};
                  s_next.tmr_run = 1'b1;
               end
               `CMD_CT_STOP:
               begin
                  s_next.tmr_run = 1'b0;
                  s_next.ctr_rdy = 1'b0;
                  s_next.cto = 1'b1;
               end
               `CMD_RTS_ON: s_next.rts_n = 1'b0;
               `CMD_RTS_OFF: s_next.rts_n = 1'b1;
               `CMD_MPI_CLR: s_next.mpi_chg = 1'b0;
               default: ;
            endcase
         end
      end
      else if (adr_i == `OFS_STATUS)
         rdat = status;
      else if (adr_i == `OFS_AUX)
      begin
         if (wr)
            s_next.auxiliary_control = wd;
      end
      else if (adr_i == `OFS_ISTAT)
         rdat = istat;
      else if (adr_i == `OFS_IMASK)
      begin
         if (wr)
            s_next.interrupt_mask = wd & `IMASK_USED;
      end
      else if (adr_i == `OFS_TPH)
      begin
         if (wr)
            s_next.timer_preload_high = wd;
      end
      else if (adr_i == `OFS_TPL)
      begin
         if (wr)
            s_next.timer_preload_low = wd;
      end
      else if (adr_i == `OFS_TXDATA)
      begin
         if (wr & s_reg.tx_en & ~s_reg.thr_full)
         begin
            s_next.thr = wd;
            s_next.thr_full = 1'b1;
         end
      end
      else if (adr_i == `OFS_RXDATA)
      begin
         rdat = head.data;
         if (rd & (s_reg.cnt != 3'h0))
         begin
            // Block mode keeps the flags of every character that left
            if (s_reg.mode_one[`M1_ERRMODE])
               s_next.acc = s_next.acc | {head.brk, head.fe, head.pe};
            s_next.rd_ptr = s_reg.rd_ptr + 2'h1;
            s_next.cnt = s_reg.cnt - 3'h1;
         end
      end
      if (req)
         s_next.dat = rdat;
      // Timer; the divisor runs from the preload, power bit 0 freezes it
      if (s_reg.auxiliary_control[`AUX_POWER])
      begin
         if (s_reg.tmr == 16'h0000)
         begin
            s_next.tmr = {s_reg.timer_preload_high, s_reg.timer_preload_low};
            tick = 1'b1;
            s_next.tick_ph = ~s_reg.tick_ph;
            if (s_reg.tmr_run)
            begin
               s_next.ctr_rdy = 1'b1;
               s_next.cto = ~s_reg.cto;
            end
         end
         else
            s_next.tmr = s_reg.tmr - 16'h0001;
      end
      // Input pin change
      s_next.mpi_prev = multipurpose_input_i;
      if (multipurpose_input_i != s_reg.mpi_prev)
         s_next.mpi_chg = 1'b1;
      // Receiver
      if (tick & rx_act)
      begin
         case (s_reg.rx_st)
            RX_IDLE:
            begin
               if (s_reg.rx_brk)
               begin
                  if (rx_line)
                  begin
                     s_next.rx_brk = 1'b0;
                     s_next.brk_chg = 1'b1;
                  end
               end
               else if (!rx_line)
               begin
                  s_next.rx_st = RX_START;
                  s_next.rx_sub = 4'h0;
               end
            end
            RX_START:
            begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `RX_MID)
               begin
                  s_next.rx_st = rx_line ? RX_IDLE : RX_DATA;
                  s_next.rx_sub = 4'h0;
                  s_next.rx_bit = 3'h0;
               end
            end
            RX_DATA:
            begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `SUB_LAST)
               begin
                  s_next.rx_sh = {rx_line, s_reg.rx_sh[7:1]};
                  s_next.rx_bit = s_reg.rx_bit + 3'h1;
                  if ({1'b0, s_reg.rx_bit} == nbits - 4'h1)
                     s_next.rx_st = (par_mode == `PAR_NONE) ? RX_STOP
                        : RX_PARITY;
               end
            end
            RX_PARITY:
            begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `SUB_LAST)
               begin
                  s_next.rx_par = rx_line;
                  s_next.rx_st = RX_STOP;
               end
            end
            default:
            begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `SUB_LAST)
               begin
                  s_next.rx_st = RX_IDLE;
                  rx_data = s_reg.rx_sh >> (4'h8 - nbits);
                  fe_now = ~rx_line;
                  case (par_mode)
                     `PAR_WITH: pe_now = (^rx_data) ^ s_reg.rx_par
                        ^ s_reg.mode_one[`M1_PTYPE];
                     `PAR_FORCE: pe_now = s_reg.rx_par
                        ^ s_reg.mode_one[`M1_PTYPE];
                     `PAR_SPECIAL: pe_now = s_reg.rx_par;
                     default: pe_now = 1'b0;
                  endcase
                  entry = '{brk: 1'b0, fe: fe_now, pe: pe_now,
                     data: rx_data};
                  if (fe_now & (rx_data == 8'h00) & (~s_reg.rx_par
                     | (par_mode == `PAR_NONE)))
                  begin
                     entry.brk = 1'b1;
                     s_next.rx_brk = 1'b1;
                     s_next.brk_chg = 1'b1;
                  end
                  push = (ch_mode != `CH_REMOTE);
               end
            end
         endcase
      end
      if (push)
      begin
         if (s_next.cnt == `FIFO_DEPTH)
            s_next.ovr = 1'b1;
         else
         begin
            wp = s_next.rd_ptr + s_next.cnt[1:0];
            s_next.fifo[wp] = entry;
            s_next.cnt = s_next.cnt + 3'h1;
         end
      end
      // Transmitter; it drains what it holds even after a disable
      if (tick)
      begin
         case (s_reg.tx_st)
            TX_IDLE:
            begin
               if (s_reg.thr_full & cts_ok & (ch_mode[0] == 1'b0))
               begin
                  s_next.tx_sh = s_reg.thr & tx_mask;
                  s_next.thr_full = 1'b0;
                  s_next.tx_par = (par_mode == `PAR_WITH)
                     ? (^(s_reg.thr & tx_mask)) ^ s_reg.mode_one[`M1_PTYPE]
                     : s_reg.mode_one[`M1_PTYPE];
                  s_next.tx_st = TX_START;
                  s_next.tx_sub = 6'h00;
                  s_next.tx_line = 1'b0;
               end
               else
                  s_next.tx_line = ~(s_reg.brk_tx & s_reg.tx_en);
            end
            TX_START:
            begin
               s_next.tx_sub = s_reg.tx_sub + 6'h01;
               if (s_reg.tx_sub[3:0] == `SUB_LAST)
               begin
                  s_next.tx_sub = 6'h00;
                  s_next.tx_st = TX_DATA;
                  s_next.tx_bit = 3'h0;
                  s_next.tx_line = s_reg.tx_sh[0];
               end
            end
            TX_DATA:
            begin
               s_next.tx_sub = s_reg.tx_sub + 6'h01;
               if (s_reg.tx_sub[3:0] == `SUB_LAST)
               begin
                  s_next.tx_sub = 6'h00;
                  s_next.tx_sh = s_reg.tx_sh >> 1;
                  s_next.tx_bit = s_reg.tx_bit + 3'h1;
                  s_next.tx_line = s_reg.tx_sh[1];
                  if ({1'b0, s_reg.tx_bit} == nbits - 4'h1)
                  begin
                     s_next.tx_st = (par_mode == `PAR_NONE) ? TX_STOP
                        : TX_PARITY;
                     s_next.tx_line = (par_mode == `PAR_NONE) ? 1'b1
                        : s_reg.tx_par;
                  end
               end
            end
            TX_PARITY:
            begin
               s_next.tx_sub = s_reg.tx_sub + 6'h01;
               if (s_reg.tx_sub[3:0] == `SUB_LAST)
               begin
                  s_next.tx_sub = 6'h00;
                  s_next.tx_st = TX_STOP;
                  s_next.tx_line = 1'b1;
               end
            end
            default:
            begin
               s_next.tx_sub = s_reg.tx_sub + 6'h01;
               if (s_reg.tx_sub == stop_len - 6'h01)
                  s_next.tx_st = TX_IDLE;
            end
         endcase
      end
      // Pins, all from flops
      if (ch_mode[0])
         s_next.txd = rxd_i;
      else if (ch_mode == `CH_LOCAL)
         s_next.txd = 1'b1;
      else
         s_next.txd = s_reg.tx_line;
      case (s_reg.auxiliary_control[2:0])
         3'h0: s_next.multipurpose_output = s_reg.rts_n;
         3'h1: s_next.multipurpose_output = s_reg.cto;
         3'h2: s_next.multipurpose_output = s_reg.tx_sub[3];
         3'h3: s_next.multipurpose_output = s_reg.tick_ph;
         3'h4: s_next.multipurpose_output = s_reg.rx_sub[3];
         3'h5: s_next.multipurpose_output = s_reg.tick_ph;
         3'h6: s_next.multipurpose_output = tx_rdy;
         default: s_next.multipurpose_output = rx_src;
      endcase
      s_next.irq = |(istat & s_reg.interrupt_mask);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
         s_reg.auxiliary_control <= `AUX_RESET;
         s_reg.rts_n <= 1'b1;
         s_reg.cto <= 1'b1;
         s_reg.txd <= 1'b1;
         s_reg.multipurpose_output <= 1'b1;
         // Idle level of the input pin, so reset leaves no false change
         s_reg.mpi_prev <= 1'b1;
         s_reg.tx_line <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // Rate set bit is held for the fixed-rate generator, which is omitted
   assign dat_o = {24'h000000, s_reg.dat};
   assign ack_o = s_reg.ack;
   assign txd_o = s_reg.txd;
   assign multipurpose_output_o = s_reg.multipurpose_output;
   assign irq_o = s_reg.irq;
endmodule

// File: hw/uart_cfg.svh
// Purpose: constants of the serial channel: offsets, fields, codes
// Assumes: byte-wide registers on a 32-bit bus, low lane only
// Notes: the package holds the types
// Operation
// - Mode one bit 6 picks receive interrupt source
// - Mode one bit 5 picks per-character or block errors
// - Mode one parity field and even/odd type bit
// - Mode two bits 7:6 pick channel loop mode
// - Stop code 0 is 9/16 bit, 5-bit adds half
// - Command bits 3..0 disable/enable transmitter and receiver
// - Disabled transmitter refuses characters
// - Error flags stored with each buffered character
// - Status high bits from head, low bits live
// - Character mode flags clear on read or command
// - Block mode flags persist until error or receiver reset
// - Auxiliary bit 7 picks baud rate set; the bit is only held, no rate generator reads it
// - Power bit 0 powers down, 1 runs
// - Three-bit select routes signal to multipurpose output
// - Interrupt status bit layout
// - Interrupt mask mirrors status, 1 enables
// - Timer preload split into upper and lower bytes
// - Mode pointer advances after mode one access
// - Clear-to-send enable gates each character start
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define OFS_MODE 8'h00
`define OFS_CLKSEL 8'h04
`define OFS_COMMAND 8'h08
`define OFS_STATUS 8'h0C
`define OFS_AUX 8'h10
`define OFS_ISTAT 8'h14
`define OFS_IMASK 8'h18
`define OFS_TPH 8'h1C
`define OFS_TPL 8'h20
`define OFS_TXDATA 8'h24
`define OFS_RXDATA 8'h28
`define AUX_RESET 8'h08
`define M1_RXIRQ 6
`define M1_ERRMODE 5
`define M1_PTYPE 2
`define AUX_BRGSET 7
`define AUX_POWER 3
`define M2_CTSEN 4
`define PAR_WITH 2'h0
`define PAR_FORCE 2'h1
`define PAR_NONE 2'h2
`define PAR_SPECIAL 2'h3
`define CH_NORMAL 2'h0
`define CH_ECHO 2'h1
`define CH_LOCAL 2'h2
`define CH_REMOTE 2'h3
`define CMD_PTR_RST 4'h1
`define CMD_RX_RST 4'h2
`define CMD_TX_RST 4'h3
`define CMD_ERR_RST 4'h4
`define CMD_BRK_CLR 4'h5
`define CMD_BRK_START 4'h6
`define CMD_BRK_STOP 4'h7
`define CMD_CT_START 4'h8
`define CMD_CT_STOP 4'h9
`define CMD_RTS_ON 4'hA
`define CMD_RTS_OFF 4'hB
`define CMD_MPI_CLR 4'hC
`define STOP_SHORT 6'h09
`define STOP_LONG 6'h11
`define STOP_FIVE 6'h08
`define RX_MID 4'h7
`define SUB_LAST 4'hF
`define FIFO_DEPTH 3'h4
`define IMASK_USED 8'hDF
`endif

// File: hw/uart_pkg.sv
// Purpose: types of the serial channel
// Assumes: constants come from uart_cfg.svh
// Notes: whole block state is one packed struct
package uart_pkg;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_START = 3'h1,
      TX_DATA = 3'h3, TX_PARITY = 3'h2, TX_STOP = 3'h6} tx_state_e;
   typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1,
      RX_DATA = 3'h3, RX_PARITY = 3'h2, RX_STOP = 3'h6} rx_state_e;
   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
      logic [7:0] data;
   } rx_entry_s;
   typedef struct packed {
      logic [7:0] mode_one, mode_two, clock_select, auxiliary_control;
      logic [7:0] interrupt_mask, timer_preload_high, timer_preload_low;
      logic ptr, ack, txd, multipurpose_output, irq;
      logic [7:0] dat;
      logic [15:0] tmr;
      logic tmr_run, cto, tick_ph, rx_en, tx_en, rts_n, brk_tx, ovr;
      logic [2:0] acc;
      logic [3:0][10:0] fifo;
      logic [1:0] rd_ptr;
      logic [2:0] cnt;
      logic mpi_chg, mpi_prev, ctr_rdy, brk_chg, rx_brk;
      logic [7:0] thr;
      logic thr_full, tx_line, tx_par;
      tx_state_e tx_st;
      logic [7:0] tx_sh;
      logic [5:0] tx_sub;
      logic [2:0] tx_bit;
      rx_state_e rx_st;
      logic [3:0] rx_sub;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
   } state_s;
endpackage

// File: verification/uart_core_sva.sv
// Purpose: port-level checks of the serial channel register block
// Assumes: Wishbone classic slave, one clock, synchronous high reset
// Notes: attached to uart_core by the bind at the foot of this file
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_core_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic multipurpose_input_i,
   input wire logic multipurpose_output_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic req;
   // A request is taken only while no answer is showing
   assign req = cyc_i && stb_i && !ack_o;
   a_ack_follows: assert property (req |=> ack_o)
      else $error("request not answered in one cycle");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("acknowledge held beyond one cycle");
   a_no_stray_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("acknowledge without a request");
   a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read data above the byte lane not zero");
   a_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> txd_o && multipurpose_output_o && !irq_o && !ack_o)
      else $error("outputs not idle after reset");
   a_istat_unused: assert property (req && !we_i && adr_i == `OFS_ISTAT
      |=> !dat_o[5])
      else $error("unused interrupt status bit reads one");
   a_mask_wo_zero: assert property (req && !we_i && adr_i == `OFS_IMASK
      |=> dat_o == 32'h0)
      else $error("write-only mask register reads non-zero");
   a_mask_off_irq: assert property (req && we_i && sel_i[0]
      && adr_i == `OFS_IMASK && dat_i[7:0] == 8'h00 |=> ##1 !irq_o)
      else $error("interrupt raised with every source masked");
   c_write: cover property (req && we_i);
   c_status_read: cover property (req && !we_i && adr_i == `OFS_STATUS);
   c_irq_rise: cover property ($rose(irq_o));
endmodule
bind uart_core uart_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .rxd_i(rxd_i), .txd_o(txd_o),
   .multipurpose_input_i(multipurpose_input_i),
   .multipurpose_output_o(multipurpose_output_o), .irq_o(irq_o));

// File: verification/uart_remote.sv
// Purpose: remote serial device facing the channel's line pins
// Assumes: 8 data bits, least significant bit first
// Notes: line idles marking; stop bit level chosen per frame
`timescale 1ns/1ps
module uart_remote #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   task automatic bit_out(input logic v);
      @(posedge clk_i);
      rxd_o <= v;
      repeat (BIT_CLKS - 1) @(posedge clk_i);
   endtask
   // A negative parity value sends no parity bit
   task automatic send(input logic [7:0] d, input int par, input logic stop);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++)
         bit_out(d[i]);
      if (par >= 0)
         bit_out(par[0]);
      bit_out(stop);
      bit_out(1'b1);
   endtask
   // Gives up after a bounded wait so a silent line cannot hang the run
   task automatic recv(output logic [7:0] d);
      int n;
      n = 0;
      d = 8'h00;
      while (txd_i !== 1'b0 && n < 4000)
      begin
         @(posedge clk_i);
         n++;
      end
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CLKS) @(posedge clk_i);
         d[i] = txd_i;
      end
      repeat (BIT_CLKS) @(posedge clk_i);
   endtask
endmodule

// File: verification/tb_uart_core.sv
// Purpose: self-checking bench of the serial channel
// Assumes: bit time of 16 clocks from the reset timer preload
// Notes: register rows first, line traffic by hand after
`timescale 1ns/1ps
`include "uart_cfg.svh"
module tb_uart_core;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, rxd_i, txd_o;
   logic multipurpose_input, multipurpose_output, irq_o, ack_o;
   logic [7:0] adr_i, b;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rd;
   int mismatches, samples_checked, cycles, lows;
   typedef struct {logic we; logic [7:0] adr, wd, mask, exp;} row_s;
   row_s rows[13] = '{
      '{0, `OFS_STATUS, 8'h00, 8'hFF, 8'h00},
      '{0, `OFS_CLKSEL, 8'h00, 8'hFF, 8'h00},
      '{0, 8'h2C, 8'h00, 8'hFF, 8'h00},
      '{0, `OFS_IMASK, 8'h00, 8'hFF, 8'h00},
      '{1, `OFS_MODE, 8'h13, 8'h00, 8'h00},
      '{1, `OFS_MODE, 8'h07, 8'h00, 8'h00},
      '{1, `OFS_COMMAND, 8'h10, 8'h00, 8'h00},
      '{0, `OFS_MODE, 8'h00, 8'hFF, 8'h13},
      '{0, `OFS_MODE, 8'h00, 8'hFF, 8'h07},
      '{0, `OFS_MODE, 8'h00, 8'hFF, 8'h07},
      '{1, `OFS_COMMAND, 8'h05, 8'h00, 8'h00},
      '{0, `OFS_STATUS, 8'h00, 8'h0C, 8'h0C},
      '{0, `OFS_ISTAT, 8'h00, 8'hA3, 8'h03}};
   uart_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i),
      .txd_o(txd_o), .multipurpose_input_i(multipurpose_input),
      .multipurpose_output_o(multipurpose_output), .irq_o(irq_o));
   uart_remote #(.BIT_CLKS(16)) u_peer (.clk_i(clk_i), .txd_i(txd_o),
      .rxd_o(rxd_i));
   always #25 clk_i = ~clk_i;
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One idle cycle after each access keeps commands three edges apart
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= a;
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      // Only the bench timeout ends a wait for the answer
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [7:0] a, m, e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, r);
      chk({24'h0, r[7:0] & m}, {24'h0, e});
   endtask
   task automatic set_mode(input logic [7:0] m1, m2);
      wb(1'b1, `OFS_COMMAND, 8'h10, rd);
      wb(1'b1, `OFS_MODE, m1, rd);
      wb(1'b1, `OFS_MODE, m2, rd);
   endtask
   task automatic watch(input int n, output int l);
      l = 0;
      repeat (n)
      begin
         @(posedge clk_i);
         if (txd_o !== 1'b1)
            l++;
      end
   endtask
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      sel_i = 4'hF;
      multipurpose_input = 1'b1;
      {mismatches, samples_checked, cycles} = '0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i])
         if (rows[i].we)
            wb(1'b1, rows[i].adr, rows[i].wd, rd);
         else
            rchk(rows[i].adr, rows[i].mask, rows[i].exp);
      chk(multipurpose_output, 32'h1);
      wb(1'b1, `OFS_COMMAND, 8'hA0, rd);
      repeat (2) @(posedge clk_i);
      chk(multipurpose_output, 32'h0);
      wb(1'b1, `OFS_IMASK, 8'h01, rd);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 32'h1);
      wb(1'b1, `OFS_IMASK, 8'h00, rd);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 32'h0);
      fork
         u_peer.recv(b);
         wb(1'b1, `OFS_TXDATA, 8'h5A, rd);
      join
      chk(b, 32'h5A);
      set_mode(8'h13, 8'h17);
      fork
         u_peer.recv(b);
         begin
            wb(1'b1, `OFS_TXDATA, 8'h81, rd);
            watch(200, lows);
            chk(lows, 32'h0);
            multipurpose_input <= 1'b0;
         end
      join
      chk(b, 32'h81);
      set_mode(8'h13, 8'h07);
      wb(1'b1, `OFS_COMMAND, 8'h08, rd);
      rchk(`OFS_STATUS, 8'h04, 8'h00);
      wb(1'b1, `OFS_TXDATA, 8'hA5, rd);
      wb(1'b1, `OFS_COMMAND, 8'h04, rd);
      watch(300, lows);
      chk(lows, 32'h0);
      set_mode(8'h03, 8'h07);
      u_peer.send(8'h33, 1, 1'b1);
      rchk(`OFS_STATUS, 8'hE1, 8'h21);
      rchk(`OFS_ISTAT, 8'h04, 8'h04);
      rchk(`OFS_RXDATA, 8'hFF, 8'h33);
      rchk(`OFS_STATUS, 8'hE1, 8'h00);
      u_peer.send(8'h01, 1, 1'b0);
      rchk(`OFS_STATUS, 8'hE1, 8'h41);
      rchk(`OFS_RXDATA, 8'hFF, 8'h01);
      set_mode(8'h23, 8'h07);
      u_peer.send(8'h33, 1, 1'b1);
      rchk(`OFS_RXDATA, 8'hFF, 8'h33);
      u_peer.send(8'h0F, 0, 1'b1);
      rchk(`OFS_RXDATA, 8'hFF, 8'h0F);
      rchk(`OFS_STATUS, 8'hE1, 8'h20);
      wb(1'b1, `OFS_COMMAND, 8'h40, rd);
      rchk(`OFS_STATUS, 8'hE1, 8'h00);
      set_mode(8'h13, 8'h87);
      wb(1'b1, `OFS_TXDATA, 8'h3C, rd);
      watch(250, lows);
      chk(lows, 32'h0);
      rchk(`OFS_RXDATA, 8'hFF, 8'h3C);
      stop_test();
   end
endmodule
